// ---- inc/afr_pkg.sv ----
// afr_pkg: constants for the analog module fault reporter
// assumes: included before the interface and design modules
package afr_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] AFR_OFS_CTRL = 8'h00;
   localparam logic [7:0] AFR_OFS_IRQN01 = 8'h04;
   localparam logic [7:0] AFR_OFS_IRQN23 = 8'h08;
   localparam logic [7:0] AFR_OFS_STATUS = 8'h0c;
   localparam logic [7:0] AFR_OFS_FAULTS = 8'h10;

   // ----------------------------------------------------------------
   // control register fields and reset values
   // ----------------------------------------------------------------
   localparam int AFR_CTRL_DET_LSB = 0;
   localparam int AFR_CTRL_ALM_LSB = 4;
   localparam int AFR_CTRL_IEN_LSB = 8;
   localparam int AFR_CTRL_WBL_LSB = 12;
   localparam logic [3:0] AFR_DET_RST = 4'hf;
   localparam logic [3:0] AFR_ALM_RST = 4'hf;
   localparam logic [3:0] AFR_IEN_RST = 4'h0;
   localparam logic [3:0] AFR_WBL_RST = 4'hf;
   localparam logic [7:0] AFR_IRQN_RST = 8'h28;

   // ----------------------------------------------------------------
   // error codes
   // ----------------------------------------------------------------
   localparam logic [15:0] AFR_CODE_NONE = 16'h0000;
   localparam logic [15:0] AFR_CODE_HW = 16'ha600;
   localparam logic [15:0] AFR_CODE_SUPPLY = 16'ha601;
   localparam logic [15:0] AFR_CODE_CAL = 16'ha603;
   localparam logic [15:0] AFR_CODE_CH_ALM = 16'ha400;
   localparam logic [15:0] AFR_CODE_CH_WBL = 16'ha000;
   localparam logic [15:0] AFR_CODE_CH_WOFF = 16'ha800;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int AFR_CLK_HZ = 50_000_000;
   localparam int AFR_BLINK_MS = 250;
   localparam int AFR_BLINK_CYC = AFR_CLK_HZ / 1000 * AFR_BLINK_MS;

   typedef enum logic [2:0] {
      AFR_LAMP_RUN = 3'b001,
      AFR_LAMP_ALARM = 3'b010,
      AFR_LAMP_WARN = 3'b100
   } afr_lamp_e;

endpackage

// ---- inc/afr_cfg_if.sv ----
// afr_cfg_if: configuration passed from the bus slave to the reporter core
// assumes: both ends on hclk
`timescale 1ns/100ps
`default_nettype none
interface afr_cfg_if;
   logic [3:0] det_en;
   logic [3:0] alm_sel;
   logic [3:0] irq_en;
   logic [3:0] wbl_sel;
   logic [31:0] irq_num;
   modport src (output det_en, alm_sel, irq_en, wbl_sel, irq_num);
   modport dst (input det_en, alm_sel, irq_en, wbl_sel, irq_num);
endinterface
`default_nettype wire

// ---- hdl/afr_regs.sv ----
// afr_regs: ahb-lite register slave holding the channel settings
// assumes: single slave on the bus, word accesses only, hclk domain
`timescale 1ns/100ps
`default_nettype none
module afr_regs
   import afr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [15:0] code,
   input wire logic [3:0] over_q,
   input wire logic [2:0] lamp,
   output logic [31:0] hrdata,
   afr_cfg_if.src cfg
);
   logic wr_pend_q;
   logic [7:0] addr_q;
   logic [15:0] ctrl_q;
   logic [31:0] irqn_q;
   logic [31:0] rdata_q;
   wire take = hsel & hready & htrans[1];
   wire wr_ctrl = wr_pend_q & (addr_q == AFR_OFS_CTRL);
   wire wr_n01 = wr_pend_q & (addr_q == AFR_OFS_IRQN01);
   wire wr_n23 = wr_pend_q & (addr_q == AFR_OFS_IRQN23);
   logic [31:0] rmux;

   // ----------------------------------------------------------------
   // read decode; unmapped words read zero
   // ----------------------------------------------------------------
   always_comb
   begin
      if (haddr == AFR_OFS_CTRL)
         rmux = {16'h0000, ctrl_q};
      else if (haddr == AFR_OFS_IRQN01)
         rmux = {16'h0000, irqn_q[15:0]};
      else if (haddr == AFR_OFS_IRQN23)
         rmux = {16'h0000, irqn_q[31:16]};
      else if (haddr == AFR_OFS_STATUS)
         rmux = {code, 9'h000, lamp, over_q};
      else
         rmux = 32'h0000_0000;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= take & hwrite;
         addr_q <= haddr;
         if (take & ~hwrite)
            rdata_q <= rmux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= {AFR_WBL_RST, AFR_IEN_RST, AFR_ALM_RST, AFR_DET_RST};
         irqn_q <= {4{AFR_IRQN_RST}};
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= hwdata[15:0];
         if (wr_n01)
            irqn_q[15:0] <= hwdata[15:0];
         if (wr_n23)
            irqn_q[31:16] <= hwdata[15:0];
      end
   end

   assign hrdata = rdata_q;
   assign cfg.det_en = ctrl_q[AFR_CTRL_DET_LSB +: 4];
   assign cfg.alm_sel = ctrl_q[AFR_CTRL_ALM_LSB +: 4];
   assign cfg.irq_en = ctrl_q[AFR_CTRL_IEN_LSB +: 4];
   assign cfg.wbl_sel = ctrl_q[AFR_CTRL_WBL_LSB +: 4];
   assign cfg.irq_num = irqn_q;
endmodule
`default_nettype wire

// ---- hdl/afr_top.sv ----
// afr_top: fault reporter of a four-input analog module
// assumes: fault inputs are asynchronous pins, registers over ahb-lite
//
// What this block does
// - hardware failure reports 16#A600 and bad calibration 16#A603, run lamp off, error lamp on.
// - an abnormal external supply reports 16#A601 with run lamp off and error lamp on.
// - an alarm-class channel over range reports 16#A400 plus channel, run off, error on.
// - blinking-warning over range reports 16#A000 plus channel, run on, error blinks.
// - quiet-warning over range reports 16#A800 plus channel, run on, error off.
// - each channel has a range detect enable, default on; disabled channels raise nothing.
// - each channel selects alarm or warning handling, default alarm.
// - each channel has an over-range interrupt enable, default off, gating its interrupt.
// - each channel has an interrupt number, default 40, sent with its interrupt.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module afr_top
   import afr_pkg::*;
#(
   parameter int BLINK_CYC = AFR_BLINK_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic hw_fail,
   input wire logic supply_bad,
   input wire logic cal_bad,
   input wire logic [3:0] over_range,
   output logic [15:0] err_code,
   output logic run_lamp,
   output logic err_lamp,
   output logic irq_req,
   output logic [7:0] irq_num
);
   afr_cfg_if cfg ();

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [6:0] s1_q;
   logic [6:0] s2_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
      end
      else
      begin
         s1_q <= {cal_bad, supply_bad, hw_fail, over_range};
         s2_q <= s1_q;
      end
   end
   wire [3:0] ovr = s2_q[3:0] & cfg.det_en;
   wire f_hw = s2_q[4];
   wire f_sup = s2_q[5];
   wire f_cal = s2_q[6];

   // ----------------------------------------------------------------
   // classification
   // ----------------------------------------------------------------
   function automatic logic [1:0] lowest(input logic [3:0] v);
      if (v[0])
         return 2'd0;
      else if (v[1])
         return 2'd1;
      else if (v[2])
         return 2'd2;
      else
         return 2'd3;
   endfunction

   wire [3:0] ch_alm = ovr & cfg.alm_sel;
   wire [3:0] ch_wbl = ovr & ~cfg.alm_sel & cfg.wbl_sel;
   wire [3:0] ch_woff = ovr & ~cfg.alm_sel & ~cfg.wbl_sel;
   logic [15:0] code_d;
   afr_lamp_e lamp_d;

   // priority: module alarms, channel alarms, blinking warnings, quiet warnings
   always_comb
   begin
      lamp_d = AFR_LAMP_ALARM;
      if (f_hw)
         code_d = AFR_CODE_HW;
      else if (f_sup)
         code_d = AFR_CODE_SUPPLY;
      else if (f_cal)
         code_d = AFR_CODE_CAL;
      else if (|ch_alm)
         code_d = AFR_CODE_CH_ALM | {14'h0000, lowest(ch_alm)};
      else if (|ch_wbl)
      begin
         code_d = AFR_CODE_CH_WBL | {14'h0000, lowest(ch_wbl)};
         lamp_d = AFR_LAMP_WARN;
      end
      else if (|ch_woff)
      begin
         code_d = AFR_CODE_CH_WOFF | {14'h0000, lowest(ch_woff)};
         lamp_d = AFR_LAMP_RUN;
      end
      else
      begin
         code_d = AFR_CODE_NONE;
         lamp_d = AFR_LAMP_RUN;
      end
   end

   // ----------------------------------------------------------------
   // blink timer, code and lamps
   // ----------------------------------------------------------------
   logic [31:0] blk_cnt_q;
   logic blink_q;
   wire blk_wrap = (blk_cnt_q == 32'(BLINK_CYC - 1));
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         blk_cnt_q <= 32'h0000_0000;
         blink_q <= 1'b0;
      end
      else
      begin
         blk_cnt_q <= blk_wrap ? 32'h0000_0000 : blk_cnt_q + 32'h0000_0001;
         if (blk_wrap)
            blink_q <= ~blink_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         err_code <= AFR_CODE_NONE;
         run_lamp <= 1'b0;
         err_lamp <= 1'b0;
      end
      else
      begin
         err_code <= code_d;
         run_lamp <= (lamp_d != AFR_LAMP_ALARM);
         err_lamp <= (lamp_d == AFR_LAMP_ALARM) | ((lamp_d == AFR_LAMP_WARN) & blink_q);
      end
   end

   // ----------------------------------------------------------------
   // over-range interrupt: one pulse per new channel edge, lowest first
   // ----------------------------------------------------------------
   logic [3:0] ovr_q;
   logic [3:0] pend_q;
   wire [3:0] rise = ovr & ~ovr_q & cfg.irq_en;
   wire [1:0] pick = lowest(pend_q);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ovr_q <= 4'h0;
         pend_q <= 4'h0;
         irq_req <= 1'b0;
         irq_num <= 8'h00;
      end
      else
      begin
         ovr_q <= ovr;
         // a new edge on the channel being served is kept, set wins
         pend_q <= (pend_q & ~((|pend_q) ? (4'h1 << pick) : 4'h0)) | rise;
         irq_req <= |pend_q;
         irq_num <= cfg.irq_num[pick*8 +: 8];
      end
   end

   // ----------------------------------------------------------------
   // registers; always zero wait, always okay
   // ----------------------------------------------------------------
   afr_regs u_regs (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .code(err_code),
      .over_q(ovr_q),
      .lamp({err_lamp, run_lamp, irq_req}),
      .hrdata(hrdata),
      .cfg(cfg)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- verif/afr_top_checker.sv ----
// afr_top_checker: timing and code relations at the reporter's pins
// assumes: bound to afr_top, single hclk domain
`timescale 1ns/100ps
`default_nettype none
module afr_top_checker
   import afr_pkg::*;
#(
   parameter int BLINK_CYC = AFR_BLINK_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hw_fail,
   input wire logic supply_bad,
   input wire logic cal_bad,
   input wire logic [3:0] over_range,
   input wire logic [15:0] err_code,
   input wire logic run_lamp,
   input wire logic err_lamp,
   input wire logic irq_req,
   input wire logic hreadyout,
   input wire logic hresp
);
   // ----------------------------------------
   // helpers: $past must not reach into reset
   // ----------------------------------------
   logic [2:0] up_q;
   logic [7:0] seen_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         up_q <= 3'h0;
         seen_q <= 8'h00;
      end
      else
      begin
         up_q <= (up_q == 3'h4) ? up_q : up_q + 3'h1;
         seen_q <= {seen_q[6:0], |over_range};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_hw;
      up_q == 3'h4 && $past(hw_fail, 3) |-> err_code == AFR_CODE_HW && !run_lamp && err_lamp;
   endproperty
   a_hw: assert property (p_hw) else $error("hardware code wrong");
   property p_sup;
      up_q == 3'h4 && !$past(hw_fail, 3) && $past(supply_bad, 3)
         |-> err_code == AFR_CODE_SUPPLY && !run_lamp && err_lamp;
   endproperty
   a_sup: assert property (p_sup) else $error("supply code wrong");
   property p_cal;
      up_q == 3'h4 && $past({hw_fail, supply_bad, cal_bad}, 3) == 3'b001
         |-> err_code == AFR_CODE_CAL && !run_lamp && err_lamp;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration code wrong");
   property p_none;
      up_q == 3'h4 && $past({hw_fail, supply_bad, cal_bad, over_range}, 3) == 7'h00
         |-> err_code == AFR_CODE_NONE && run_lamp && !err_lamp;
   endproperty
   a_none: assert property (p_none) else $error("idle state wrong");
   property p_ch_alm;
      err_code[15:8] == 8'ha4 |-> err_code[7:2] == 6'h0 && !run_lamp && err_lamp;
   endproperty
   a_ch_alm: assert property (p_ch_alm) else $error("channel alarm lamps wrong");
   property p_blink;
      err_code[15:8] == 8'ha0 |-> err_code[7:2] == 6'h0 && run_lamp;
   endproperty
   a_blink: assert property (p_blink) else $error("blink warning lamps wrong");
   property p_quiet;
      err_code[15:8] == 8'ha8 |-> err_code[7:2] == 6'h0 && run_lamp && !err_lamp;
   endproperty
   a_quiet: assert property (p_quiet) else $error("quiet warning lamps wrong");
   property p_irq;
      irq_req |-> |seen_q[7:2];
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without over range");
   property p_resp;
      hreadyout && !hresp;
   endproperty
   a_resp: assert property (p_resp) else $error("bus answer not ready okay");
   c_hw: cover property (err_code == AFR_CODE_HW);
   c_warn: cover property (err_code[15:8] == 8'ha0 ##1 err_lamp);
   c_irq: cover property (irq_req ##1 irq_req);
endmodule
`default_nettype wire

// ---- verif/afr_cpu_model.sv ----
// afr_cpu_model: controller side, an ahb-lite master reading module status
// assumes: hready is the one slave's hreadyout; calls start just after an edge
`timescale 1ns/100ps
`default_nettype none
module afr_cpu_model
(
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata,
   output logic rd_done,
   output logic [31:0] rd_data
);
   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata, rd_done, rd_data} = '0;
   end
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= adr;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      // read data is taken at this edge, one edge after the slave registered it
      rd_data <= hrdata;
      rd_done <= !wr;
      // released data lines never keep the last value
      hwdata <= ~wd;
      @(posedge hclk);
      rd_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- verif/tb_afr_top.sv ----
// tb_afr_top: self-checking bench for the fault reporter
// assumes: afr_pkg compiled first; blink half period shortened to 4 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_afr_top;
   import afr_pkg::*;
   localparam int BLINK_CYC = 4;
   logic hclk, hresetn, hw_fail, supply_bad, cal_bad, hsel, hwrite, rd_done;
   logic hreadyout, hresp, run_lamp, err_lamp, irq_req, last;
   logic [3:0] over_range;
   logic [1:0] htrans;
   logic [7:0] haddr, irq_num;
   logic [15:0] err_code, prev_code;
   logic [31:0] hwdata, hrdata, rd_data;
   logic [7:0] irqn[4];
   logic [17:0] q_code[$];
   logic [31:0] q_val[$];
   logic [17:0] e;
   int num_errors = 0;
   int n_compared = 0;
   int toggles;
   afr_top #(.BLINK_CYC(BLINK_CYC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .hw_fail(hw_fail), .supply_bad(supply_bad), .cal_bad(cal_bad), .over_range(over_range),
      .err_code(err_code), .run_lamp(run_lamp), .err_lamp(err_lamp), .irq_req(irq_req),
      .irq_num(irq_num));
   afr_cpu_model u_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .rd_done(rd_done),
      .rd_data(rd_data));
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] pop_val();
      return (q_val.size() == 0) ? 32'hdeadbeef : q_val.pop_front();
   endfunction
   // --------------------------------------------
   // monitor: every new code, read and interrupt
   // --------------------------------------------
   always @(posedge hclk)
   begin
      if (hresetn === 1'b1 && err_code !== prev_code)
      begin
         prev_code = err_code;
         e = (q_code.size() == 0) ? 18'h3ffff : q_code.pop_front();
         // blinking lamp phase is free, so only its code and run lamp are fixed
         check({err_code, run_lamp, e[17:10] == 8'ha0 ? e[0] : err_lamp}, {14'h0, e});
      end
      if (rd_done === 1'b1)
         check(rd_data, pop_val());
      if (irq_req === 1'b1)
         check({24'h0, irq_num}, pop_val());
   end
   task automatic pins(input logic [2:0] m, input logic [3:0] ch, input logic [15:0] c);
      logic run;
      run = c == 16'h0 || c[15:8] == 8'ha0 || c[15:8] == 8'ha8;
      if (c != prev_code)
         q_code.push_back({c, run, c != 16'h0 && c[15:8] != 8'ha8});
      {hw_fail, supply_bad, cal_bad} <= m;
      over_range <= ch;
      repeat (7) @(posedge hclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      q_val.push_back(exp);
      u_cpu.xfer(1'b0, a, 32'h0);
   endtask
   task automatic finish_test();
      // a result that never showed up is as bad as a wrong one
      if (q_code.size() + q_val.size() != 0)
      begin
         num_errors++;
         $display("mismatch at %0t: %0d expected results never seen", $time,
            q_code.size() + q_val.size());
      end
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #100us;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test();
   end
   initial
   begin
      {hresetn, hw_fail, supply_bad, cal_bad, over_range} = '0;
      prev_code = 16'h0;
      void'($urandom(32'haaff));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(AFR_OFS_CTRL, 32'h0000f0ff);
      rd(AFR_OFS_IRQN01, 32'h00002828);
      rd(AFR_OFS_IRQN23, 32'h00002828);
      rd(8'h1c, 32'h0);
      rd(AFR_OFS_STATUS, 32'h00000020);
      $display("test reset_values done");
      for (int c = 0; c < 4; c++)
      begin
         pins(3'b000, 4'h1 << c, AFR_CODE_CH_ALM + 16'(c));
         pins(3'b000, 4'h0, AFR_CODE_NONE);
      end
      pins(3'b001, 4'h4, AFR_CODE_CAL);
      pins(3'b011, 4'h4, AFR_CODE_SUPPLY);
      pins(3'b111, 4'h4, AFR_CODE_HW);
      pins(3'b010, 4'h4, AFR_CODE_SUPPLY);
      pins(3'b000, 4'h4, AFR_CODE_CH_ALM + 16'h2);
      pins(3'b000, 4'h0, AFR_CODE_NONE);
      $display("test alarms done");
      for (int c = 0; c < 4; c++)
         irqn[c] = 8'($urandom);
      u_cpu.xfer(1'b1, AFR_OFS_IRQN01, {16'h0, irqn[1], irqn[0]});
      u_cpu.xfer(1'b1, AFR_OFS_IRQN23, {16'h0, irqn[3], irqn[2]});
      u_cpu.xfer(1'b1, AFR_OFS_CTRL, 32'h00005f0f);
      rd(AFR_OFS_CTRL, 32'h00005f0f);
      for (int c = 0; c < 4; c++)
      begin
         q_val.push_back({24'h0, irqn[c]});
         pins(3'b000, 4'h1 << c,
            ((c % 2) ? AFR_CODE_CH_WOFF : AFR_CODE_CH_WBL) + 16'(c));
         if (c == 0)
         begin
            toggles = 0;
            last = err_lamp;
            repeat (16)
            begin
               @(posedge hclk);
               toggles += (err_lamp !== last);
               last = err_lamp;
            end
            check(toggles, 4);
         end
         pins(3'b000, 4'h0, AFR_CODE_NONE);
      end
      $display("test warnings done");
      u_cpu.xfer(1'b1, AFR_OFS_CTRL, 32'h00005f8f);
      q_val.push_back({24'h0, irqn[0]});
      q_val.push_back({24'h0, irqn[3]});
      pins(3'b000, 4'h9, AFR_CODE_CH_ALM + 16'h3);
      pins(3'b000, 4'h1, AFR_CODE_CH_WBL);
      pins(3'b000, 4'h0, AFR_CODE_NONE);
      u_cpu.xfer(1'b1, AFR_OFS_CTRL, 32'h00005f0b);
      pins(3'b000, 4'h4, AFR_CODE_NONE);
      rd(AFR_OFS_STATUS, 32'h00000020);
      pins(3'b000, 4'h0, AFR_CODE_NONE);
      $display("test precedence_and_disable done");
      finish_test();
   end
endmodule
bind afr_top afr_top_checker #(.BLINK_CYC(BLINK_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .hw_fail(hw_fail), .supply_bad(supply_bad), .cal_bad(cal_bad), .over_range(over_range),
   .err_code(err_code), .run_lamp(run_lamp), .err_lamp(err_lamp), .irq_req(irq_req),
   .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire
